// ==== verilog/eiv_pkg.sv ====
// Package for the external interrupt and vector block: vectors, offsets, field layouts
`default_nettype none
package eiv_pkg;
    // Program vector addresses, lowest first
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT = 16'h0001;
    localparam logic [15:0] VEC_PCLO = 16'h0002;
    localparam logic [15:0] VEC_PCHI = 16'h0003;
    localparam logic [15:0] VEC_FIRST_PERIPH = 16'h0004;
    localparam logic [15:0] VEC_LAST = 16'h0010;
    localparam int NUM_PERIPH = 13;
    localparam int NUM_SRC = 16;
    // Register offsets on the plain register port
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_ENABLE = 4'h1;
    localparam logic [3:0] OFF_FLAGS = 4'h2;
    localparam logic [3:0] OFF_MASK_LO = 4'h3;
    localparam logic [3:0] OFF_MASK_HI = 4'h4;
    localparam logic [3:0] OFF_PERIPH_LO = 4'h5;
    localparam logic [3:0] OFF_PERIPH_HI = 4'h6;
    localparam logic [3:0] OFF_VECTOR = 4'h7;
    // Bit positions in the enable, flag and control registers
    localparam int BIT_EXT = 6;
    localparam int BIT_PCHI = 5;
    localparam int BIT_PCLO = 4;
    localparam int SENSE_HI = 1;
    localparam int SENSE_LO = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int NUM_PC_LO = 8;
    localparam int NUM_PC_HI = 4;
    // Sense control encodings
    typedef enum logic [1:0]
    {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } eiv_sense_type;
    // Register port request
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } eiv_req_type;
    // Vector offered to the processor core
    typedef struct packed
    {
        logic valid;
        logic [15:0] addr;
    } eiv_vec_type;
endpackage : eiv_pkg
`default_nettype wire

// ==== verilog/eiv_sync.sv ====
// Two-stage synchroniser with change detection for pin inputs
`default_nettype none
module eiv_sync #(
    parameter int WIDTH = 12
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] prev_out
);
    logic [WIDTH-1:0] meta_r;
    // Two flip-flops per bit, then a delayed copy for edge detection
    genvar i;
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk)
        begin
            if (!nrst)
            begin
                meta_r[i] <= 1'b1;
                sync_out[i] <= 1'b1;
                prev_out[i] <= 1'b1;
            end
            else if (ce)
            begin
                meta_r[i] <= async_in[i];
                sync_out[i] <= meta_r[i];
                prev_out[i] <= sync_out[i];
            end
        end
    end
endmodule : eiv_sync
`default_nettype wire

// ==== verilog/eiv_top.sv ====
// External interrupt detection, flag registers and vector priority for the processor core
// How it works
// - All reset sources use vector 0x0000
// - External pin request uses vector 0x0001
// - Low pin-change group uses vector 0x0002
// - High pin-change group uses vector 0x0003
// - Peripheral vectors 0x0004 to 0x0010 in order
// - Pins trigger even when driven as outputs
// - Any enabled low pin toggle raises request
// - Any enabled high pin toggle raises request
// - Mask bit gates each pin's contribution
// - Pin changes detected only while clock runs, also for wake
// - External pin senses falling, rising, any change or low
// - Low level requests continuously while low
// - Edges recognised only while clock runs
// - Low level detected only while clock runs, also for wake
// - Level gone before start-up: wake, no interrupt
// - Early removal resumes after sleep, no service
// - Sense 00 low, 01 change, 10 fall, 11 rise
// - Pulses over one clock always caught in the three edge modes
// - Flags clear on service entry or written one
`default_nettype none
module eiv_top
    import eiv_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic ext_irq_pin,
    input wire logic [eiv_pkg::NUM_PC_LO-1:0] pin_change_low_inputs,
    input wire logic [eiv_pkg::NUM_PC_HI-1:0] pin_change_high_inputs,
    input wire logic [eiv_pkg::NUM_PERIPH-1:0] periph_irq,
    input wire logic global_irq_en,
    input wire logic vec_ack,
    input wire logic sleeping,
    input wire eiv_pkg::eiv_req_type req,
    output logic [7:0] rdata,
    output eiv_pkg::eiv_vec_type vec,
    output logic wake_req
);
    localparam int NPC = NUM_PC_LO + NUM_PC_HI;
    // Peripheral enables are split over two byte registers at this bit
    localparam int PERIPH_LO_W = 8;

    logic [NPC-1:0] pc_sync;
    logic [NPC-1:0] pc_prev;
    logic ext_sync;
    logic ext_prev;
    logic [1:0] sense_r;
    logic en_ext_r;
    logic en_pclo_r;
    logic en_pchi_r;
    logic [NUM_PC_LO-1:0] mask_lo_r;
    logic [NUM_PC_HI-1:0] mask_hi_r;
    logic flag_ext_r;
    logic flag_pclo_r;
    logic flag_pchi_r;
    logic [NUM_PERIPH-1:0] periph_en_r;
    logic ext_event;
    logic pclo_event;
    logic pchi_event;
    logic [NUM_SRC-1:0] pending;
    logic [15:0] vec_nxt;
    logic found;
    logic [7:0] rdata_nxt;
    logic wr_flags;
    logic ext_level;

    // Pins are sampled from the pad, so port direction does not matter
    eiv_sync #(.WIDTH(NPC + 1)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .async_in({ext_irq_pin, pin_change_high_inputs, pin_change_low_inputs}),
        .sync_out({ext_sync, pc_sync}),
        .prev_out({ext_prev, pc_prev})
    );

    // Masked toggle detection per group
    always_comb
    begin
        pclo_event = |((pc_sync[NUM_PC_LO-1:0] ^ pc_prev[NUM_PC_LO-1:0]) & mask_lo_r);
        pchi_event = |((pc_sync[NPC-1:NUM_PC_LO] ^ pc_prev[NPC-1:NUM_PC_LO]) & mask_hi_r);
    end

    // External pin sense selection; edges need the running clock
    always_comb
    begin
        ext_level = 1'b0;
        ext_event = 1'b0;
        unique case (eiv_sense_type'(sense_r))
            SENSE_LOW: ext_level = !ext_sync;
            SENSE_ANY: ext_event = ext_sync ^ ext_prev;
            SENSE_FALL: ext_event = ext_prev & !ext_sync;
            SENSE_RISE: ext_event = !ext_prev & ext_sync;
        endcase
    end

    // Wake request: synchronised pin level and group events, needs the clock, registered for the output
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wake_req <= 1'b0;
        else if (ce)
            wake_req <= sleeping & ((en_ext_r & ext_level) | (en_pclo_r & pclo_event)
                        | (en_pchi_r & pchi_event));
    end

    assign wr_flags = req.wr && (req.addr == OFF_FLAGS);

    // Sticky flags: set wins over clear by write-one or service entry
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            flag_ext_r <= 1'b0;
            flag_pclo_r <= 1'b0;
            flag_pchi_r <= 1'b0;
        end
        else if (ce)
        begin
            flag_ext_r <= ext_event | (flag_ext_r & (sense_r != SENSE_LOW)
                & !(wr_flags & req.wdata[BIT_EXT]) & !(vec_ack & vec.valid & vec.addr == VEC_EXT));
            flag_pclo_r <= pclo_event | (flag_pclo_r & !(wr_flags & req.wdata[BIT_PCLO])
                & !(vec_ack & vec.valid & vec.addr == VEC_PCLO));
            flag_pchi_r <= pchi_event | (flag_pchi_r & !(wr_flags & req.wdata[BIT_PCHI])
                & !(vec_ack & vec.valid & vec.addr == VEC_PCHI));
        end
    end

    // Control registers written by software
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sense_r <= SENSE_LOW;
            en_ext_r <= 1'b0;
            en_pclo_r <= 1'b0;
            en_pchi_r <= 1'b0;
            mask_lo_r <= '0;
            mask_hi_r <= '0;
            periph_en_r <= '0;
        end
        else if (ce && req.wr)
        begin
            unique case (req.addr)
                OFF_CTRL: sense_r <= req.wdata[SENSE_HI:SENSE_LO];
                OFF_ENABLE:
                begin
                    en_ext_r <= req.wdata[BIT_EXT];
                    en_pchi_r <= req.wdata[BIT_PCHI];
                    en_pclo_r <= req.wdata[BIT_PCLO];
                end
                OFF_MASK_LO: mask_lo_r <= req.wdata[NUM_PC_LO-1:0];
                OFF_MASK_HI: mask_hi_r <= req.wdata[NUM_PC_HI-1:0];
                OFF_PERIPH_LO: periph_en_r[PERIPH_LO_W-1:0] <= req.wdata[PERIPH_LO_W-1:0];
                OFF_PERIPH_HI: periph_en_r[NUM_PERIPH-1:PERIPH_LO_W] <= req.wdata[NUM_PERIPH-PERIPH_LO_W-1:0];
                default: ;
            endcase
        end
    end

    // Pending sources indexed by vector number; level mode has no flag
    always_comb
    begin
        pending = '0;
        pending[VEC_EXT[3:0]] = en_ext_r & (flag_ext_r | ext_level);
        pending[VEC_PCLO[3:0]] = en_pclo_r & flag_pclo_r;
        pending[VEC_PCHI[3:0]] = en_pchi_r & flag_pchi_r;
        pending[NUM_SRC-1:VEC_FIRST_PERIPH[3:0]] = periph_irq[NUM_PERIPH-2:0] & periph_en_r[NUM_PERIPH-2:0];
    end

    // Lowest pending vector wins; the last source sits at 0x0010
    always_comb
    begin
        vec_nxt = VEC_RESET;
        found = 1'b0;
        for (int i = NUM_SRC - 1; i >= 1; i--)
        begin
            if (pending[i])
            begin
                vec_nxt = 16'(i);
                found = 1'b1;
            end
        end
        if (!found && periph_irq[NUM_PERIPH-1] && periph_en_r[NUM_PERIPH-1])
        begin
            vec_nxt = VEC_LAST;
            found = 1'b1;
        end
    end

    // Registered vector offer; withdrawn for a cycle after acknowledge
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            vec.valid <= 1'b0;
            vec.addr <= VEC_RESET;
        end
        else if (ce)
        begin
            vec.valid <= found & global_irq_en & !(vec_ack & vec.valid);
            vec.addr <= vec_nxt;
        end
    end

    // Read mux
    always_comb
    begin
        rdata_nxt = RESET_BYTE;
        unique case (req.addr)
            OFF_CTRL: rdata_nxt[SENSE_HI:SENSE_LO] = sense_r;
            OFF_ENABLE:
            begin
                rdata_nxt[BIT_EXT] = en_ext_r;
                rdata_nxt[BIT_PCHI] = en_pchi_r;
                rdata_nxt[BIT_PCLO] = en_pclo_r;
            end
            OFF_FLAGS:
            begin
                rdata_nxt[BIT_EXT] = flag_ext_r;
                rdata_nxt[BIT_PCHI] = flag_pchi_r;
                rdata_nxt[BIT_PCLO] = flag_pclo_r;
            end
            OFF_MASK_LO: rdata_nxt[NUM_PC_LO-1:0] = mask_lo_r;
            OFF_MASK_HI: rdata_nxt[NUM_PC_HI-1:0] = mask_hi_r;
            OFF_PERIPH_LO: rdata_nxt[PERIPH_LO_W-1:0] = periph_en_r[PERIPH_LO_W-1:0];
            OFF_PERIPH_HI: rdata_nxt[NUM_PERIPH-PERIPH_LO_W-1:0] = periph_en_r[NUM_PERIPH-1:PERIPH_LO_W];
            OFF_VECTOR: rdata_nxt = vec.addr[7:0];
            default: rdata_nxt = RESET_BYTE;
        endcase
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata <= RESET_BYTE;
        else if (ce)
            rdata <= req.rd ? rdata_nxt : RESET_BYTE;
    end

    // Assertions
    ext_fall_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && en_ext_r && sense_r == SENSE_FALL && ext_prev && !ext_sync |=> flag_ext_r)
        else $error("falling edge did not set flag");
    pclo_set_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && |((pc_sync[NUM_PC_LO-1:0] ^ pc_prev[NUM_PC_LO-1:0]) & mask_lo_r) |=> flag_pclo_r)
        else $error("low group toggle lost");
    pchi_set_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && pchi_event |=> flag_pchi_r)
        else $error("high group toggle lost");
    mask_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && mask_lo_r == '0 && mask_hi_r == '0 && !flag_pclo_r && !flag_pchi_r |=> !flag_pclo_r && !flag_pchi_r)
        else $error("masked pin changed a group");
    level_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && global_irq_en && en_ext_r && sense_r == SENSE_LOW && !ext_sync && !vec_ack
        |=> vec.valid && vec.addr == VEC_EXT)
        else $error("low level not offered");
    reset_vec_a: assert property (@(posedge clk)
        !nrst |=> vec.addr == VEC_RESET && !vec.valid)
        else $error("reset vector wrong");
    prio_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && pending[VEC_EXT[3:0]] |=> vec.addr == VEC_EXT)
        else $error("lowest vector not chosen");
    ack_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && vec_ack && vec.valid && vec.addr == VEC_PCHI && !pchi_event |=> !flag_pchi_r)
        else $error("service entry did not clear flag");
    wclr_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && wr_flags && req.wdata[BIT_PCLO] && !pclo_event |=> !flag_pclo_r)
        else $error("write one did not clear flag");
    wake_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && sleeping && en_ext_r && ext_level |=> wake_req)
        else $error("no wake on low level");
    pc_wake_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && sleeping && en_pclo_r && pclo_event |=> wake_req)
        else $error("no wake on pin change");
    wake_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !sleeping |=> !wake_req)
        else $error("wake raised while awake");
    ext_lvl_clr_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && sense_r == SENSE_LOW |=> !flag_ext_r)
        else $error("external flag kept in level mode");
    vec_drop_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && vec_ack && vec.valid |=> !vec.valid)
        else $error("offer not withdrawn after acknowledge");
    ext_rise_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && sense_r == SENSE_RISE && !ext_prev && ext_sync |=> flag_ext_r)
        else $error("rising edge did not set flag");
    ext_any_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && sense_r == SENSE_ANY && (ext_prev != ext_sync) |=> flag_ext_r)
        else $error("pin change did not set flag");
    // Covers for the main scenarios
    pc_cov_c: cover property (@(posedge clk) disable iff (!nrst) pclo_event ##1 flag_pclo_r);
    ext_cov_c: cover property (@(posedge clk) disable iff (!nrst) vec.valid && vec.addr == VEC_EXT && vec_ack);
    wake_cov_c: cover property (@(posedge clk) disable iff (!nrst) wake_req);
    last_cov_c: cover property (@(posedge clk) disable iff (!nrst) vec.valid && vec.addr == VEC_LAST);
    rise_cov_c: cover property (@(posedge clk) disable iff (!nrst) sense_r == SENSE_RISE && ext_event);
endmodule : eiv_top
`default_nettype wire

// ==== verification/eiv_core_model.sv ====
// Processor core model that takes offered vectors
`default_nettype none
module eiv_core_model
    import eiv_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic take,
    input wire logic [3:0] slow,
    input wire eiv_pkg::eiv_vec_type vec,
    output logic vec_ack,
    output logic [15:0] taken
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] dly_r;
    // Acknowledge an offer after slow cycles with a one-cycle pulse
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            vec_ack <= 1'b0;
            dly_r <= 4'h0;
            taken <= 16'h0000;
        end
        else if (take && vec.valid)
        begin
            dly_r <= dly_r + 4'h1;
            vec_ack <= (dly_r == slow);
            if (dly_r == slow)
                taken <= vec.addr;
        end
        else
        begin
            vec_ack <= 1'b0;
            dly_r <= 4'h0;
        end
    end
endmodule : eiv_core_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the external interrupt and vector block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import eiv_pkg::*;
    logic clk, nrst, ce, pin, sleeping, gie, ack, take, wake;
    logic [7:0] pcl;
    logic [3:0] pch;
    logic [12:0] per;
    logic [7:0] rdata;
    logic [15:0] taken;
    eiv_req_type req;
    eiv_vec_type vec;
    int n_errors = 0;
    int samples_checked = 0;

    eiv_top dut_u (.clk(clk), .nrst(nrst), .ce(ce), .ext_irq_pin(pin), .pin_change_low_inputs(pcl),
        .pin_change_high_inputs(pch), .periph_irq(per), .global_irq_en(gie), .vec_ack(ack),
        .sleeping(sleeping), .req(req), .rdata(rdata), .vec(vec), .wake_req(wake));
    eiv_core_model core_u (.clk(clk), .nrst(nrst), .take(take), .slow(4'h2), .vec(vec), .vec_ack(ack),
        .taken(taken));

    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task print_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b0};
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd

    task setp(input logic [7:0] l, input logic [3:0] h, input logic p);
        @(posedge clk);
        pcl <= l;
        pch <= h;
        pin <= p;
        repeat (6) @(posedge clk);
    endtask : setp

    // Bounded wait: m 0 offered vector, 1 wake request, 2 taken vector
    task wait_on(input logic [15:0] e, input int m);
        int i;
        logic [15:0] s;
        #1;
        for (i = 0; i < 40; i++)
        begin
            s = (m == 0) ? (vec.valid === 1'b1 ? vec.addr : 16'hFFFF) : (m == 1) ? {15'h0000, wake} : taken;
            if (s === e)
                break;
            @(posedge clk) #1;
        end
        if (i == 40)
        begin
            n_errors++;
            print_verdict();
        end
        else
            chk(s, e);
    endtask : wait_on

    // Overall run limit
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        pin = 1'b1;
        pcl = 8'hFF;
        pch = 4'hF;
        per = 13'h0000;
        gie = 1'b0;
        take = 1'b0;
        sleeping = 1'b0;
        req = '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk({15'h0000, vec.valid}, 16'h0000);
        chk(vec.addr, VEC_RESET);
        rd(4'h8, 8'h00);
        rd(OFF_VECTOR, VEC_RESET[7:0]);
        // Pin-change groups, masks and flag clearing
        wr(OFF_ENABLE, 8'h30);
        wr(OFF_MASK_LO, 8'h08);
        wr(OFF_MASK_HI, 8'h04);
        rd(OFF_ENABLE, 8'h30);
        rd(OFF_MASK_LO, 8'h08);
        rd(OFF_MASK_HI, 8'h04);
        setp(8'hFB, 4'hF, 1'b1);
        rd(OFF_FLAGS, 8'h00);
        setp(8'hF3, 4'hF, 1'b1);
        rd(OFF_FLAGS, 8'h10);
        setp(8'hF3, 4'hB, 1'b1);
        rd(OFF_FLAGS, 8'h30);
        wr(OFF_FLAGS, 8'h10);
        rd(OFF_FLAGS, 8'h20);
        setp(8'hFB, 4'hB, 1'b1);
        @(posedge clk);
        gie <= 1'b1;
        wait_on(VEC_PCLO, 0);
        @(posedge clk);
        take <= 1'b1;
        wait_on(VEC_PCHI, 0);
        wait_on(VEC_PCHI, 2);
        @(posedge clk);
        take <= 1'b0;
        rd(OFF_FLAGS, 8'h00);
        // External pin in each edge mode
        wr(OFF_ENABLE, 8'h40);
        for (int s = 1; s < 4; s++)
        begin
            wr(OFF_CTRL, s[7:0]);
            rd(OFF_CTRL, s[7:0]);
            wr(OFF_FLAGS, 8'h70);
            setp(8'hFB, 4'hB, 1'b0);
            rd(OFF_FLAGS, (s != 3) ? 8'h40 : 8'h00);
            wr(OFF_FLAGS, 8'h40);
            setp(8'hFB, 4'hB, 1'b1);
            rd(OFF_FLAGS, (s != 2) ? 8'h40 : 8'h00);
        end
        // Level mode, priority and peripheral vectors
        wr(OFF_CTRL, 8'h00);
        wr(OFF_PERIPH_LO, 8'hFF);
        wr(OFF_PERIPH_HI, 8'h1F);
        rd(OFF_PERIPH_LO, 8'hFF);
        rd(OFF_PERIPH_HI, 8'h1F);
        @(posedge clk);
        per <= 13'h0001;
        setp(8'hFB, 4'hB, 1'b0);
        wait_on(VEC_EXT, 0);
        repeat (20) @(posedge clk);
        wait_on(VEC_EXT, 0);
        setp(8'hFB, 4'hB, 1'b1);
        wait_on(VEC_FIRST_PERIPH, 0);
        for (int k = 1; k < NUM_PERIPH; k++)
        begin
            @(posedge clk);
            per <= 13'h0001 << k;
            wait_on(VEC_FIRST_PERIPH + 16'(k), 0);
        end
        rd(OFF_VECTOR, VEC_LAST[7:0]);
        // Wake from sleep by a masked pin change
        @(posedge clk);
        per <= 13'h0000;
        gie <= 1'b0;
        sleeping <= 1'b1;
        wr(OFF_ENABLE, 8'h10);
        // The wake pulse from a pin change stands one cycle, so watch from the change on
        @(posedge clk);
        pcl <= 8'hF3;
        wait_on(16'h0001, 1);
        // Second reset, then wake by a low level
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wr(OFF_ENABLE, 8'h40);
        setp(8'hF3, 4'hB, 1'b0);
        wait_on(16'h0001, 1);
        // Level removed before any service: no vector offered, wake ends
        setp(8'hF3, 4'hB, 1'b1);
        @(posedge clk);
        gie <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, vec.valid}, 16'h0000);
        chk({15'h0000, wake}, 16'h0000);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
